// ### verilog/vmd_pkg.sv
// Package with register map, field positions and widths of the detector
package vmd_pkg;
  localparam int AXIS_W = 14;
  localparam int THS_W = 13;
  localparam int CNT_W = 8;
  localparam logic [7:0] CFG_ADDR = 8'h5f;
  localparam logic [7:0] THS_HI_ADDR = 8'h60;
  localparam logic [7:0] THS_LO_ADDR = 8'h61;
  localparam logic [7:0] INT_SRC_ADDR = 8'h0c;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] THS_HI_RST = 8'h00;
  localparam logic [7:0] THS_LO_RST = 8'h00;
  localparam int CFG_LATCH_BIT = 6;
  localparam int CFG_PRESET_SRC_BIT = 5;
  localparam int CFG_REF_HOLD_BIT = 4;
  localparam int CFG_EN_BIT = 3;
  localparam int THS_HI_CLR_MODE_BIT = 7;
  localparam int THS_HI_FIELD_MSB = 4;
  localparam int ODR_MAX_HZ = 400;
endpackage

// ### verilog/vmd_mag_if.sv
// Interface between the detector core and its magnitude comparator
`timescale 1ns/1ps
interface vmd_mag_if;
  logic signed [vmd_pkg::AXIS_W-1:0] cur_x;
  logic signed [vmd_pkg::AXIS_W-1:0] cur_y;
  logic signed [vmd_pkg::AXIS_W-1:0] cur_z;
  logic signed [vmd_pkg::AXIS_W-1:0] ref_x;
  logic signed [vmd_pkg::AXIS_W-1:0] ref_y;
  logic signed [vmd_pkg::AXIS_W-1:0] ref_z;
  logic [vmd_pkg::THS_W-1:0] ths;
  logic above;
  modport calc (input cur_x, cur_y, cur_z, ref_x, ref_y, ref_z, ths,
                output above);
  modport core (output cur_x, cur_y, cur_z, ref_x, ref_y, ref_z, ths,
                input above);
endinterface

// ### verilog/vmd_magnitude.sv
// Combinational vector distance versus threshold comparator
`timescale 1ns/1ps
module vmd_magnitude (
  // Operands and result
  vmd_mag_if.calc mag
);
  localparam int DW = vmd_pkg::AXIS_W + 1;
  localparam int SW = 2 * DW + 2;

  function automatic logic [SW-1:0] sq_diff(
    input logic signed [vmd_pkg::AXIS_W-1:0] a,
    input logic signed [vmd_pkg::AXIS_W-1:0] b);
    logic signed [DW-1:0] d;
    d = DW'(a) - DW'(b);
    sq_diff = SW'(d * d);
  endfunction

  // Squares compared so no root is needed; both sides are non-negative
  wire [SW-1:0] dist_sq = sq_diff(mag.cur_x, mag.ref_x)
                        + sq_diff(mag.cur_y, mag.ref_y)
                        + sq_diff(mag.cur_z, mag.ref_z);
  wire [SW-1:0] ths_sq = SW'(mag.ths) * SW'(mag.ths);
  assign mag.above = dist_sq > ths_sq;
endmodule

// ### verilog/vmd_detector.sv
// Vector-magnitude change detector with debounce and reference control
`timescale 1ns/1ps
module vmd_detector (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Samples at the output data rate
  input wire logic smp_valid,
  input wire logic signed [vmd_pkg::AXIS_W-1:0] smp_x,
  input wire logic signed [vmd_pkg::AXIS_W-1:0] smp_y,
  input wire logic signed [vmd_pkg::AXIS_W-1:0] smp_z,
  // Settings held in neighbouring registers
  input wire logic [vmd_pkg::CNT_W-1:0] debounce_count,
  input wire logic signed [vmd_pkg::AXIS_W-1:0] preset_x,
  input wire logic signed [vmd_pkg::AXIS_W-1:0] preset_y,
  input wire logic signed [vmd_pkg::AXIS_W-1:0] preset_z,
  input wire logic preset_wr,
  // Event flag
  output logic vm_event
);
  localparam int AW = vmd_pkg::AXIS_W;
  localparam int CW = vmd_pkg::CNT_W;

  logic [7:0] cfg_q;
  logic [7:0] ths_hi_q;
  logic [7:0] ths_lo_q;
  logic [7:0] rdata_q;
  logic flag_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic signed [AW-1:0] cur_x_q, cur_y_q, cur_z_q;
  logic signed [AW-1:0] ref_x_q, ref_y_q, ref_z_q;

  vmd_mag_if mag ();
  vmd_magnitude u_mag (
    .mag(mag)
  );

  // Register decode
  wire cfg_wr = reg_wr && reg_addr == vmd_pkg::CFG_ADDR;
  wire ths_hi_wr = reg_wr && reg_addr == vmd_pkg::THS_HI_ADDR;
  wire ths_lo_wr = reg_wr && reg_addr == vmd_pkg::THS_LO_ADDR;
  wire int_rd = reg_rd && reg_addr == vmd_pkg::INT_SRC_ADDR;
  wire [7:0] rd_mux = (reg_addr == vmd_pkg::CFG_ADDR) ? cfg_q :
                      (reg_addr == vmd_pkg::THS_HI_ADDR) ? ths_hi_q :
                      (reg_addr == vmd_pkg::THS_LO_ADDR) ? ths_lo_q : 8'h00;

  wire en = cfg_q[vmd_pkg::CFG_EN_BIT];
  wire latch = cfg_q[vmd_pkg::CFG_LATCH_BIT];
  wire from_preset = cfg_q[vmd_pkg::CFG_PRESET_SRC_BIT];
  wire ref_hold = cfg_q[vmd_pkg::CFG_REF_HOLD_BIT];
  wire clr_mode = ths_hi_q[vmd_pkg::THS_HI_CLR_MODE_BIT];
  wire en_rise = cfg_wr && reg_wdata[vmd_pkg::CFG_EN_BIT] && !en;
  wire new_preset = cfg_wr ? reg_wdata[vmd_pkg::CFG_PRESET_SRC_BIT]
                           : from_preset;
  wire live_preset = from_preset && ref_hold && preset_wr;

  // Threshold in output LSBs, so full-scale changes scale it for free
  assign mag.ths = {ths_hi_q[vmd_pkg::THS_HI_FIELD_MSB:0],
                    ths_lo_q};
  assign mag.cur_x = cur_x_q;
  assign mag.cur_y = cur_y_q;
  assign mag.cur_z = cur_z_q;
  assign mag.ref_x = ref_x_q;
  assign mag.ref_y = ref_y_q;
  assign mag.ref_z = ref_z_q;

  // One evaluation per sample: the counter steps at the data rate
  logic eval_q;
  wire above = mag.above;
  wire at_limit = cnt_q >= debounce_count;
  always_comb begin
    cnt_d = cnt_q;
    if (!en) begin
      cnt_d = '0;
    end else if (eval_q && above) begin
      if (!at_limit) begin
        cnt_d = cnt_q + CW'(1);
      end
    end else if (eval_q && clr_mode) begin
      cnt_d = '0;
    end else if (eval_q && cnt_q != '0) begin
      cnt_d = cnt_q - CW'(1);
    end
  end
  wire reached = cnt_d >= debounce_count;
  wire trigger = en && eval_q && above && reached;
  // Zero count would hold the flag forever; it then needs a live hit
  wire live_level = en && reached &&
                    (debounce_count != '0 || (eval_q && above));

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cfg_q <= vmd_pkg::CFG_RST;
      ths_hi_q <= vmd_pkg::THS_HI_RST;
      ths_lo_q <= vmd_pkg::THS_LO_RST;
      rdata_q <= 8'h00;
    end else begin
      if (cfg_wr) begin
        cfg_q <= reg_wdata;
      end
      if (ths_hi_wr) begin
        ths_hi_q <= reg_wdata;
      end
      if (ths_lo_wr) begin
        ths_lo_q <= reg_wdata;
      end
      if (reg_rd) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // Latest sample, which also serves as the capture source at enable
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cur_x_q <= '0;
      cur_y_q <= '0;
      cur_z_q <= '0;
      eval_q <= 1'b0;
    end else begin
      eval_q <= smp_valid && en;
      if (smp_valid) begin
        cur_x_q <= smp_x;
        cur_y_q <= smp_y;
        cur_z_q <= smp_z;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ref_x_q <= '0;
      ref_y_q <= '0;
      ref_z_q <= '0;
    end else if ((en_rise && new_preset) || live_preset) begin
      ref_x_q <= preset_x;
      ref_y_q <= preset_y;
      ref_z_q <= preset_z;
    end else if (en_rise || (trigger && !ref_hold)) begin
      ref_x_q <= cur_x_q;
      ref_y_q <= cur_y_q;
      ref_z_q <= cur_z_q;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
      flag_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      if (!latch) begin
        flag_q <= live_level;
      end else if (trigger) begin
        flag_q <= 1'b1;
      end else if (int_rd) begin
        flag_q <= 1'b0;
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign vm_event = flag_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  property p_live_clear;
    !latch && en && eval_q && !above && clr_mode && debounce_count != '0
      && !cfg_wr |=> !vm_event;
  endproperty
  a_live_clear: assert property (p_live_clear)
    else $error("live flag not cleared below threshold");

  property p_latch_hold;
    latch && vm_event && !int_rd && !cfg_wr |=> vm_event;
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("latched flag dropped without a read");

  property p_clear_mode;
    en && eval_q && !above && clr_mode && !cfg_wr |=> cnt_q == '0;
  endproperty
  a_clear_mode: assert property (p_clear_mode)
    else $error("counter not zeroed in clear mode");

  property p_decrement;
    en && eval_q && !above && !clr_mode && cnt_q != '0 && !cfg_wr
      |=> cnt_q == $past(cnt_q) - CW'(1);
  endproperty
  a_decrement: assert property (p_decrement)
    else $error("counter not decremented by one");

  property p_count_up;
    en && eval_q && above && cnt_q < debounce_count && !cfg_wr
      |=> cnt_q == $past(cnt_q) + CW'(1);
  endproperty
  a_count_up: assert property (p_count_up)
    else $error("counter not incremented above threshold");

  property p_enable_capture;
    en_rise && !reg_wdata[vmd_pkg::CFG_PRESET_SRC_BIT]
      |=> ref_x_q == $past(cur_x_q) && ref_z_q == $past(cur_z_q);
  endproperty
  a_enable_capture: assert property (p_enable_capture)
    else $error("reference not captured from sample at enable");

  property p_enable_preset;
    en_rise && reg_wdata[vmd_pkg::CFG_PRESET_SRC_BIT]
      |=> ref_y_q == $past(preset_y);
  endproperty
  a_enable_preset: assert property (p_enable_preset)
    else $error("reference not loaded from preset at enable");

  property p_hold;
    en && ref_hold && !cfg_wr && !live_preset |=> $stable(ref_x_q);
  endproperty
  a_hold: assert property (p_hold)
    else $error("held reference changed");

  property p_live_preset;
    live_preset && !cfg_wr |=> ref_z_q == $past(preset_z);
  endproperty
  a_live_preset: assert property (p_live_preset)
    else $error("preset write did not reach reference");

  property p_disabled;
    (!en && !cfg_wr) [*2] |-> cnt_q == '0 && !eval_q;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("counter active while disabled");
endmodule

// ### sim/tb.sv
// Self-checking bench for the vector-magnitude detector
`timescale 1ns/1ps
module tb;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic smp_valid = 1'b0;
  logic signed [vmd_pkg::AXIS_W-1:0] smp_x = '0;
  logic signed [vmd_pkg::AXIS_W-1:0] smp_y = '0;
  logic signed [vmd_pkg::AXIS_W-1:0] smp_z = '0;
  logic [vmd_pkg::CNT_W-1:0] debounce_count = 8'h02;
  logic signed [vmd_pkg::AXIS_W-1:0] preset_x = '0;
  logic signed [vmd_pkg::AXIS_W-1:0] preset_y = '0;
  logic signed [vmd_pkg::AXIS_W-1:0] preset_z = '0;
  logic preset_wr = 1'b0;
  logic vm_event;
  int bad_count = 0;
  int comparisons = 0;

  always #5 sys_clk = ~sys_clk;

  vmd_detector vmd_detector_i (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .smp_valid(smp_valid),
    .smp_x(smp_x),
    .smp_y(smp_y),
    .smp_z(smp_z),
    .debounce_count(debounce_count),
    .preset_x(preset_x),
    .preset_y(preset_y),
    .preset_z(preset_z),
    .preset_wr(preset_wr),
    .vm_event(vm_event)
  );

  task automatic tally_and_finish;
    if (bad_count == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // All strobes are one-cycle pulses raised just after an edge; an idle
  // edge follows so back-to-back calls never re-raise a strobe at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge sys_clk);
    #1 reg_wr = 1'b0;
    @(posedge sys_clk);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge sys_clk);
    #1 reg_rd = 1'b0;
    check(reg_rdata, exp);
    @(posedge sys_clk);
    #1;
  endtask

  // Flag is looked at two edges after the sample edge
  task automatic smp(input logic [13:0] x, input logic [13:0] y,
                     input logic [13:0] z, input logic e);
    smp_x = x;
    smp_y = y;
    smp_z = z;
    smp_valid = 1'b1;
    @(posedge sys_clk);
    #1 smp_valid = 1'b0;
    repeat (2) @(posedge sys_clk); // Sample spacing
    #1 check({7'h00, vm_event}, {7'h00, e});
  endtask

  initial begin
    repeat (16) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    @(posedge sys_clk);
    #1 rd(vmd_pkg::CFG_ADDR, vmd_pkg::CFG_RST);
    rd(vmd_pkg::THS_HI_ADDR, vmd_pkg::THS_HI_RST);
    rd(vmd_pkg::THS_LO_ADDR, vmd_pkg::THS_LO_RST);
    wr(vmd_pkg::THS_HI_ADDR, 8'hff);
    rd(vmd_pkg::THS_HI_ADDR, 8'hff);
    wr(vmd_pkg::THS_LO_ADDR, 8'h0a);
    wr(vmd_pkg::THS_HI_ADDR, 8'h00);
    rd(8'h62, 8'h00);
    smp(14'h000, 14'h000, 14'h000, 1'h0);
    wr(vmd_pkg::CFG_ADDR, 8'h08);
    smp(14'h014, 14'h000, 14'h000, 1'h0);
    smp(14'h014, 14'h000, 14'h000, 1'h1);
    smp(14'h014, 14'h000, 14'h000, 1'h0);
    smp(14'h028, 14'h000, 14'h000, 1'h1);
    wr(vmd_pkg::THS_HI_ADDR, 8'h80);
    smp(14'h028, 14'h000, 14'h000, 1'h0);
    smp(14'h03c, 14'h000, 14'h000, 1'h0);
    // Distance of exactly the threshold must not count as above
    smp(14'h02e, 14'h008, 14'h000, 1'h0);
    smp(14'h02e, 14'h008, 14'h001, 1'h0);
    smp(14'h02e, 14'h008, 14'h001, 1'h1);
    wr(vmd_pkg::CFG_ADDR, 8'h00);
    smp(14'h1f4, 14'h000, 14'h000, 1'h0);
    debounce_count = 8'h01;
    wr(vmd_pkg::CFG_ADDR, 8'h48);
    // Sample equal to the one captured at enable must not count
    smp(14'h1f4, 14'h000, 14'h000, 1'h0);
    smp(14'h000, 14'h000, 14'h000, 1'h1);
    smp(14'h000, 14'h000, 14'h000, 1'h1);
    rd(vmd_pkg::INT_SRC_ADDR, 8'h00);
    @(posedge sys_clk);
    #1 check({7'h00, vm_event}, 8'h00);
    wr(vmd_pkg::CFG_ADDR, 8'h00);
    preset_x = 14'h064;
    wr(vmd_pkg::CFG_ADDR, 8'h38);
    smp(14'h064, 14'h000, 14'h000, 1'h0);
    smp(14'h000, 14'h000, 14'h000, 1'h1);
    smp(14'h000, 14'h000, 14'h000, 1'h1);
    preset_x = 14'h000;
    preset_wr = 1'b1;
    @(posedge sys_clk);
    #1 preset_wr = 1'b0;
    smp(14'h000, 14'h000, 14'h000, 1'h0);
    tally_and_finish;
  end

  // Tests need well under a thousand cycles; this cuts a hang short
  initial begin
    repeat (5000) @(posedge sys_clk);
    bad_count++;
    tally_and_finish;
  end
endmodule
